// ===== rtl/l2cst_pkg.sv
/*
 Package for the second-level cache pin controller: register indices, field
 positions, reset values, counts, state and operation codes, pin bundles.
 Assumes a single clock domain (pclk) and an APB register port.
*/
package l2cst_pkg;

	localparam int APB_AW = 12;
	localparam logic [9:0] CEC_IDX = 10'h053;
	localparam logic [9:0] SDC_IDX = 10'h054;
	localparam logic [9:0] STAT_IDX = 10'h055;
	localparam int CEC_DCACHE_BIT = 5;
	localparam int SDC_64M_BIT = 1;
	localparam logic [7:0] CEC_RST = 8'h00;
	localparam logic [7:0] SDC_RST = 8'h00;

	localparam logic [1:0] LAST_BEAT = 2'h3;
	localparam logic [1:0] TAG_WAIT_LAST = 2'h2;
	localparam logic [1:0] STRAP_WAIT_LAST = 2'h3;
	localparam logic [1:0] RF_IGNORE_LAST = 2'h2;

	localparam logic [1:0] RF_IDLE = 2'h0;
	localparam logic [1:0] RF_DRIVE = 2'h1;
	localparam logic [1:0] RF_WAIT = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_STROBE = 3'h1,
		ST_TAG = 3'h3,
		ST_BURST = 3'h2,
		ST_TAGWR = 3'h6,
		ST_DONE = 3'h7,
		ST_PDOWN = 3'h4
	} l2cst_state_e;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_WR_FULL = 3'h1,
		OP_WR_PART = 3'h2,
		OP_FILL = 3'h3,
		OP_INVAL = 3'h4,
		OP_PDOWN = 3'h5
	} l2cst_op_e;

	typedef struct packed {
		logic burst_advance_n;
		logic cache_addr_strobe_n;
		logic cache_select_n;
		logic cache_out_en_n;
		logic global_wr_en_n;
		logic byte_wr_en_n;
		logic tag_wr_en_n;
		logic tag_oe;
		logic [7:0] tag_out;
	} l2cst_pins_s;

	typedef struct packed {
		logic valid;
		l2cst_op_e op;
		logic [7:0] tag;
		logic [7:0] new_tag;
	} l2cst_req_s;

	localparam l2cst_pins_s PINS_IDLE = '{
		burst_advance_n: 1'b1,
		cache_addr_strobe_n: 1'b1,
		cache_select_n: 1'b1,
		cache_out_en_n: 1'b1,
		global_wr_en_n: 1'b1,
		byte_wr_en_n: 1'b1,
		tag_wr_en_n: 1'b1,
		tag_oe: 1'b0,
		tag_out: 8'h00
	};

endpackage

// ===== rtl/l2cst_sync.sv
/*
 Two-flop synchroniser for pin inputs.
 Assumes the destination clock is pclk; the first stage feeds only the second.
*/
`timescale 1ns/1ps
module l2cst_sync import l2cst_pkg::*; #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} l2cst_sync_s;

	l2cst_sync_s s_r;
	l2cst_sync_s s_nxt;

	always_comb begin
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.s2;
endmodule

// ===== rtl/l2cst_tagcmp.sv
/*
 Registered comparator of the tag read back from the tag bus against the
 upper address bits of the pending access.
 Assumes both inputs are already in the pclk domain.
*/
`timescale 1ns/1ps
module l2cst_tagcmp import l2cst_pkg::*; #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Compare
	input wire logic [W-1:0] tag_seen,
	input wire logic [W-1:0] tag_want,
	output logic hit
);
	typedef struct packed {
		logic hit;
	} l2cst_cmp_s;

	l2cst_cmp_s s_r;
	l2cst_cmp_s s_nxt;

	always_comb begin
		s_nxt.hit = (tag_seen == tag_want);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hit = s_r.hit;
endmodule

// ===== rtl/l2cst_ctrl.sv
/*
 Second-level cache pin controller: burst SRAM strobes, tag bus and tag write,
 shared refresh-handshake / fifth-row-select pin with reset strap, APB registers.
 Assumes host-side logic presents one request at a time on the pclk domain and
 that the tag bus and shared pin are resolved outside from the enables.
*/
`timescale 1ns/1ps
module l2cst_ctrl import l2cst_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Cache access request
	input wire l2cst_req_s req,
	output logic req_ready,
	output logic done,
	output logic hit,
	// Cache pins
	output l2cst_pins_s cache_pins,
	input wire logic [7:0] tag_bus_in,
	// Shared pin
	input wire logic shared_in,
	output logic shared_out,
	output logic shared_oe,
	// Memory controller side
	input wire logic row5_select_n,
	input wire logic refresh_req,
	output logic refresh_ack,
	output logic dcache_present,
	output logic fifth_mode
);
	typedef struct packed {
		l2cst_state_e st;
		l2cst_op_e op;
		logic [7:0] tag;
		logic [7:0] new_tag;
		logic [1:0] cnt;
		logic hit;
		logic done;
		logic [7:0] cec;
		logic [7:0] sdc;
		logic strap_done;
		logic [1:0] strap_cnt;
		logic [1:0] rf_phase;
		logic [1:0] rf_cnt;
		logic rf_ack;
		logic sh_out;
		logic sh_oe;
		l2cst_pins_s pins;
		logic [31:0] prdata;
	} l2cst_ctl_s;

	localparam l2cst_ctl_s CTL_RST = '{
		st: ST_IDLE, op: OP_READ, tag: 8'h00, new_tag: 8'h00, cnt: 2'h0,
		hit: 1'b0, done: 1'b0, cec: CEC_RST, sdc: SDC_RST, strap_done: 1'b0,
		strap_cnt: 2'h0, rf_phase: RF_IDLE, rf_cnt: 2'h0, rf_ack: 1'b0,
		sh_out: 1'b0, sh_oe: 1'b0, pins: PINS_IDLE, prdata: 32'h0
	};

	l2cst_ctl_s s_r;
	l2cst_ctl_s s_nxt;
	logic [7:0] tag_sync;
	logic sh_sync;
	logic cmp_hit;
	logic [9:0] idx;
	logic mapped;
	logic fifth_now;

	l2cst_sync #(.W(8)) u_tag_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(tag_bus_in),
		.q(tag_sync)
	);

	l2cst_sync #(.W(1)) u_sh_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(shared_in),
		.q(sh_sync)
	);

	l2cst_tagcmp #(.W(8)) u_cmp (
		.pclk(pclk),
		.presetn(presetn),
		.tag_seen(tag_sync),
		.tag_want(s_r.tag),
		.hit(cmp_hit)
	);

	assign idx = paddr[11:2];
	assign mapped = (idx == CEC_IDX) || (idx == SDC_IDX) || (idx == STAT_IDX);
	assign fifth_now = s_r.sdc[SDC_64M_BIT] && !s_r.cec[CEC_DCACHE_BIT];

	function automatic l2cst_pins_s pins_for(input l2cst_state_e st, input l2cst_op_e op,
			input logic [1:0] beat, input logic [7:0] nt);
		l2cst_pins_s p;
		p = PINS_IDLE;
		case (st)
			ST_STROBE: begin
				p.cache_addr_strobe_n = 1'b0;
				p.cache_select_n = 1'b0;
			end
			ST_PDOWN: begin
				p.cache_addr_strobe_n = 1'b0;
			end
			ST_BURST: begin
				p.burst_advance_n = (beat == 2'h0);
				case (op)
					OP_READ: p.cache_out_en_n = 1'b0;
					OP_WR_PART: p.byte_wr_en_n = 1'b0;
					default: p.global_wr_en_n = 1'b0;
				endcase
			end
			ST_TAGWR: begin
				p.tag_wr_en_n = 1'b0;
			end
			default: begin
			end
		endcase
		// tag bus out on fill and invalidate
		if ((st == ST_TAGWR) || ((op == OP_FILL) && ((st == ST_STROBE) || (st == ST_BURST)))) begin
			p.tag_oe = 1'b1;
			p.tag_out = nt;
		end
		return p;
	endfunction

	assign req_ready = (s_r.st == ST_IDLE) && s_r.strap_done;

	always_comb begin
		s_nxt = s_r;
		s_nxt.rf_ack = 1'b0;
		case (s_r.st)
			ST_IDLE: begin
				if (req.valid && req_ready) begin
					s_nxt.op = req.op;
					s_nxt.tag = req.tag;
					s_nxt.new_tag = req.new_tag;
					s_nxt.cnt = 2'h0;
					s_nxt.hit = 1'b0;
					case (req.op)
						OP_INVAL: s_nxt.st = ST_TAGWR;
						OP_PDOWN: s_nxt.st = ST_PDOWN;
						default: s_nxt.st = ST_STROBE;
					endcase
				end
			end
			ST_STROBE: begin
				s_nxt.cnt = 2'h0;
				s_nxt.st = (s_r.op == OP_FILL) ? ST_BURST : ST_TAG;
			end
			ST_TAG: begin
				// no data strobes on a miss
				if (s_r.cnt == TAG_WAIT_LAST) begin
					s_nxt.cnt = 2'h0;
					s_nxt.hit = cmp_hit;
					s_nxt.st = cmp_hit ? ST_BURST : ST_DONE;
				end else begin
					s_nxt.cnt = s_r.cnt + 2'h1;
				end
			end
			ST_BURST: begin
				if (s_r.cnt == LAST_BEAT) begin
					s_nxt.st = (s_r.op == OP_FILL) ? ST_TAGWR : ST_DONE;
				end else begin
					s_nxt.cnt = s_r.cnt + 2'h1;
				end
			end
			ST_TAGWR: s_nxt.st = ST_DONE;
			ST_PDOWN: s_nxt.st = ST_DONE;
			ST_DONE: s_nxt.st = ST_IDLE;
			default: s_nxt.st = ST_IDLE;
		endcase
		s_nxt.done = (s_nxt.st == ST_DONE);
		// Pins follow the next state so they leave a flop in step with it
		// select stays high outside our own strobe
		s_nxt.pins = pins_for(s_nxt.st, s_nxt.op, s_nxt.cnt, s_nxt.new_tag);

		if (psel && penable && pwrite && (idx == CEC_IDX)) begin
			s_nxt.cec = pwdata[7:0];
		end
		if (psel && penable && pwrite && (idx == SDC_IDX)) begin
			s_nxt.sdc = pwdata[7:0];
		end
		if (psel && !penable && !pwrite) begin
			case (idx)
				CEC_IDX: s_nxt.prdata = {24'h0, s_r.cec};
				SDC_IDX: s_nxt.prdata = {24'h0, s_r.sdc};
				STAT_IDX: s_nxt.prdata = {29'h0, s_r.hit, !req_ready, fifth_now};
				default: s_nxt.prdata = 32'h0;
			endcase
		end

		// strap caught after release, wins over a register write
		if (!s_r.strap_done) begin
			if (s_r.strap_cnt == STRAP_WAIT_LAST) begin
				s_nxt.cec[CEC_DCACHE_BIT] = sh_sync;
				s_nxt.strap_done = 1'b1;
			end else begin
				s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
			end
		end

		// Pin stays released until the strap is known, keeping the pull-down readable
		if (!s_r.strap_done) begin
			s_nxt.sh_oe = 1'b0;
			s_nxt.sh_out = 1'b0;
		end else if (fifth_now) begin
			s_nxt.sh_oe = 1'b1;
			s_nxt.sh_out = row5_select_n;
			s_nxt.rf_phase = RF_IDLE;
		end else begin
			// handshake whenever fifth select is off
			s_nxt.sh_out = 1'b1;
			s_nxt.sh_oe = 1'b0;
			case (s_r.rf_phase)
				RF_IDLE: begin
					if (refresh_req) begin
						s_nxt.sh_oe = 1'b1;
						s_nxt.rf_phase = RF_DRIVE;
					end
				end
				RF_DRIVE: begin
					s_nxt.rf_cnt = 2'h0;
					s_nxt.rf_phase = RF_WAIT;
				end
				RF_WAIT: begin
					// Our own drive is still in the synchroniser for two cycles
					if (s_r.rf_cnt != RF_IGNORE_LAST) begin
						s_nxt.rf_cnt = s_r.rf_cnt + 2'h1;
					end else if (sh_sync) begin
						s_nxt.rf_ack = 1'b1;
						s_nxt.rf_phase = RF_IDLE;
					end
				end
				default: s_nxt.rf_phase = RF_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= CTL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign done = s_r.done;
	assign hit = s_r.hit;
	assign cache_pins = s_r.pins;
	assign shared_out = s_r.sh_out;
	assign shared_oe = s_r.sh_oe;
	assign refresh_ack = s_r.rf_ack;
	assign dcache_present = s_r.cec[CEC_DCACHE_BIT];
	assign fifth_mode = fifth_now;

	a_adv_after_beat: assert property (@(posedge pclk) disable iff (!presetn)
		!cache_pins.burst_advance_n |-> $past(s_r.st) == ST_BURST && s_r.st == ST_BURST)
		else $error("advance outside a burst");

	a_strobe_single: assert property (@(posedge pclk) disable iff (!presetn)
		!cache_pins.cache_addr_strobe_n |=> cache_pins.cache_addr_strobe_n)
		else $error("address strobe longer than one cycle");

	a_access_select: assert property (@(posedge pclk) disable iff (!presetn)
		(!cache_pins.cache_addr_strobe_n && !cache_pins.cache_select_n) |-> s_r.op != OP_PDOWN
		##1 (s_r.st == ST_TAG || s_r.st == ST_BURST))
		else $error("select strobe not followed by access");

	a_pdown_strobe: assert property (@(posedge pclk) disable iff (!presetn)
		(!cache_pins.cache_addr_strobe_n && cache_pins.cache_select_n) |-> s_r.op == OP_PDOWN
		##1 done)
		else $error("power-down strobe on wrong operation");

	a_oe_read_only: assert property (@(posedge pclk) disable iff (!presetn)
		!cache_pins.cache_out_en_n |-> s_r.op == OP_READ && !cache_pins.tag_oe && s_r.hit)
		else $error("output enable outside a read hit");

	a_gwe_full: assert property (@(posedge pclk) disable iff (!presetn)
		!cache_pins.global_wr_en_n |-> cache_pins.byte_wr_en_n &&
		(s_r.op == OP_WR_FULL || s_r.op == OP_FILL))
		else $error("global write on wrong operation");

	a_bwe_part: assert property (@(posedge pclk) disable iff (!presetn)
		!cache_pins.byte_wr_en_n |-> cache_pins.global_wr_en_n && s_r.op == OP_WR_PART)
		else $error("byte write without global high");

	a_tag_dir: assert property (@(posedge pclk) disable iff (!presetn)
		cache_pins.tag_oe |-> (s_r.op == OP_FILL || s_r.op == OP_INVAL))
		else $error("tag bus driven on a processor access");

	a_twe_data: assert property (@(posedge pclk) disable iff (!presetn)
		!cache_pins.tag_wr_en_n |-> cache_pins.tag_oe && cache_pins.tag_out == s_r.new_tag
		##1 done)
		else $error("tag write without new tag on bus");

	a_fifth_drive: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.strap_done && fifth_now && $stable(fifth_now)) |=>
		shared_oe && shared_out == $past(row5_select_n))
		else $error("fifth select not driven");

	a_strap_catch: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s_r.strap_done) |-> s_r.cec[CEC_DCACHE_BIT] == $past(sh_sync))
		else $error("strap level not captured");

	a_miss_nodata: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.st == ST_TAG && s_r.cnt == TAG_WAIT_LAST && !cmp_hit) |=>
		cache_pins.cache_out_en_n && cache_pins.global_wr_en_n && cache_pins.byte_wr_en_n)
		else $error("data strobe after tag miss");
endmodule

// ===== test/l2cst_far.sv
/*
 Far side of the cache pins: external tag RAM and a DRAM cache on the shared pin.
 Assumes pin levels are resolved here from the controller's enables.
*/
`timescale 1ns/1ps
module l2cst_far import l2cst_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Controller pins
	input wire l2cst_pins_s cache_pins,
	input wire logic shared_out,
	input wire logic shared_oe,
	// Build option
	input wire logic has_dcache,
	// Resolved pin levels
	output logic [7:0] tag_bus_in,
	output logic shared_in,
	// Data array state
	output logic cache_up
);
	logic [7:0] tag_ram;
	logic [3:0] since_rst;
	logic [2:0] rf_cnt;
	logic was_req;
	logic rf_drv;
	always_ff @(posedge pclk) begin
		if (!cache_pins.tag_wr_en_n && cache_pins.tag_oe) begin
			tag_ram <= cache_pins.tag_out;
		end
	end
	// power changes only at cache strobes; host strobe never reaches the array
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cache_up <= 1'b0;
		end else if (!cache_pins.cache_addr_strobe_n) begin
			cache_up <= !cache_pins.cache_select_n;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_rst <= 4'h0;
			rf_cnt <= 3'h0;
			was_req <= 1'b0;
		end else begin
			if (since_rst != 4'hf) begin
				since_rst <= since_rst + 4'h1;
			end
			was_req <= shared_oe && shared_out;
			if (rf_cnt != 3'h0) begin
				rf_cnt <= rf_cnt - 3'h1;
			end else if (has_dcache && was_req && !shared_oe) begin
				rf_cnt <= 3'h7;
			end
		end
	end
	assign rf_drv = (rf_cnt != 3'h0) && (rf_cnt < 3'h6);
	assign tag_bus_in = cache_pins.tag_oe ? cache_pins.tag_out : tag_ram;
	assign shared_in = shared_oe ? shared_out : (since_rst < 4'h8) ? has_dcache : rf_drv;
endmodule

// ===== test/tb_l2cst_ctrl.sv
/*
 Testbench for the cache pin controller: APB register checks, cache operations, shared pin.
 Assumes the far-side model answers on the tag bus and the shared pin.
*/
`timescale 1ns/1ps
module tb_l2cst_ctrl import l2cst_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic row5_select_n = 1, refresh_req = 0, strap = 0, err;
	logic pready, pslverr, req_ready, done, hit, shared_out, shared_oe, shared_in;
	logic refresh_ack, dcache_present, fifth_mode, seen_drv, cache_up;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [7:0] tag_bus_in;
	l2cst_req_s req = '0;
	l2cst_pins_s pins;
	int fails = 0, compares = 0, n;
	localparam logic [11:0] A_CEC = {CEC_IDX, 2'b00};
	localparam logic [11:0] A_SDC = {SDC_IDX, 2'b00};
	localparam logic [11:0] A_ST = {STAT_IDX, 2'b00};
	always #50 pclk = ~pclk;
	l2cst_ctrl dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .req(req), .req_ready(req_ready), .done(done), .hit(hit),
		.cache_pins(pins), .tag_bus_in(tag_bus_in), .shared_in(shared_in),
		.shared_out(shared_out), .shared_oe(shared_oe), .row5_select_n(row5_select_n),
		.refresh_req(refresh_req), .refresh_ack(refresh_ack),
		.dcache_present(dcache_present), .fifth_mode(fifth_mode));
	l2cst_far far_u (.pclk(pclk), .presetn(presetn), .cache_pins(pins),
		.shared_out(shared_out), .shared_oe(shared_oe), .has_dcache(strap),
		.tag_bus_in(tag_bus_in), .shared_in(shared_in), .cache_up(cache_up));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Pin counts per op, one nibble each: adv coe gwe bwe twe toe pdown access
	task automatic do_op(input l2cst_op_e op, input logic [7:0] tg, input logic [7:0] nt,
		input int lat, input logic [31:0] ec, input logic eh, input logic chit);
		logic [31:0] c;
		c = '0;
		n = 0;
		@(posedge pclk);
		req <= '{1'b1, op, tg, nt};
		@(posedge pclk);
		req.valid <= 1'b0;
		while (n < 20) begin
			#1;
			n++;
			c += {3'b0, !pins.burst_advance_n, 3'b0, !pins.cache_out_en_n, 3'b0,
				!pins.global_wr_en_n, 3'b0, !pins.byte_wr_en_n, 3'b0, !pins.tag_wr_en_n,
				3'b0, pins.tag_oe, 3'b0, !pins.cache_addr_strobe_n && pins.cache_select_n,
				3'b0, !pins.cache_addr_strobe_n && !pins.cache_select_n};
			if (done === 1'b1) break;
			@(posedge pclk);
		end
		chk("latency", n, lat);
		chk("pin counts", c, ec);
		if (chit) chk("hit", hit, eh);
	endtask
	task automatic reset_run();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		#1 chk("ready before strap", req_ready, 1'b0);
		repeat (6) @(posedge pclk);
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		fails++;
		print_verdict();
	end
	initial begin
		reset_run();
		apb(0, A_CEC, 0);
		chk("cec reset", rd, {24'h0, CEC_RST});
		apb(0, A_SDC, 0);
		chk("sdc reset", rd, {24'h0, SDC_RST});
		apb(1, A_SDC, 32'h2);
		apb(0, A_SDC, 0);
		chk("sdc rw", rd, 32'h2);
		apb(0, 12'h200, 0);
		chk("unmapped", {rd[30:0], err}, 32'h1);
		apb(0, A_ST, 0);
		chk("fifth on", {rd[0], fifth_mode}, 2'b11);
		@(posedge pclk);
		row5_select_n <= 1'b0;
		repeat (2) @(posedge pclk);
		#1 chk("row5 low", {shared_oe, shared_out}, 2'b10);
		@(posedge pclk);
		row5_select_n <= 1'b1;
		repeat (2) @(posedge pclk);
		#1 chk("row5 high", {shared_oe, shared_out}, 2'b11);
		apb(1, A_CEC, 32'h20);
		apb(0, A_ST, 0);
		chk("fifth off", {rd[0], dcache_present}, 2'b01);
		$display("test registers ended");
		do_op(OP_FILL, 8'h00, 8'h5a, 7, 32'h30401601, 0, 1);
		do_op(OP_READ, 8'h5a, 8'h00, 9, 32'h34000001, 1, 1);
		do_op(OP_READ, 8'h33, 8'h00, 5, 32'h00000001, 0, 1);
		do_op(OP_WR_FULL, 8'h5a, 8'h00, 9, 32'h30400001, 1, 1);
		do_op(OP_WR_PART, 8'h5a, 8'h00, 9, 32'h30040001, 1, 1);
		do_op(OP_INVAL, 8'h00, 8'h00, 2, 32'h00001100, 0, 0);
		do_op(OP_READ, 8'h5a, 8'h00, 5, 32'h00000001, 0, 1);
		do_op(OP_PDOWN, 8'h00, 8'h00, 2, 32'h00000010, 0, 0);
		chk("powered down", cache_up, 1'b0);
		do_op(OP_READ, 8'h33, 8'h00, 5, 32'h00000001, 0, 1);
		chk("powered up", cache_up, 1'b1);
		$display("test cache operations ended");
		strap = 1'b1;
		reset_run();
		apb(0, A_CEC, 0);
		chk("strap", rd[5], 1'b1);
		apb(1, A_SDC, 32'h2);
		apb(0, A_ST, 0);
		chk("no fifth", rd[0], 1'b0);
		@(posedge pclk);
		refresh_req <= 1'b1;
		@(posedge pclk);
		refresh_req <= 1'b0;
		seen_drv = 1'b0;
		n = 0;
		while (n < 30) begin
			#1;
			n++;
			seen_drv |= shared_oe && shared_out;
			if (refresh_ack === 1'b1) break;
			@(posedge pclk);
		end
		chk("refresh", {seen_drv, refresh_ack}, 2'b11);
		$display("test shared pin ended");
		print_verdict();
	end
endmodule
